/* File: inc/cpu_ctrl_pkg.sv */
// Purpose: constants, field layout and carrier types of the cpu status and core control bank
// Assumes: one core clock, synchronous active-high reset, apb register access
// Notes:   byte offsets and the info word layout are fixed here and used everywhere else
`default_nettype none
package cpu_ctrl_pkg;
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 32;
    localparam logic [11:0] OFF_STATUS    = 12'h000;
    localparam logic [11:0] OFF_CORE      = 12'h004;
    localparam logic [11:0] OFF_PAGE      = 12'h008;
    localparam logic [11:0] OFF_INFO      = 12'h00C;
    // status word bit positions
    localparam int ST_OA   = 15;
    localparam int ST_OB   = 14;
    localparam int ST_SA   = 13;
    localparam int ST_SB   = 12;
    localparam int ST_OAB  = 11;
    localparam int ST_SAB  = 10;
    localparam int ST_DA   = 9;
    localparam int ST_DC   = 8;
    localparam int ST_IPL  = 5;
    localparam int ST_RA   = 4;
    localparam int ST_N    = 3;
    localparam int ST_OV   = 2;
    localparam int ST_Z    = 1;
    localparam int ST_C    = 0;
    // core control bit positions
    localparam int CC_US     = 12;
    localparam int CC_EDT    = 11;
    localparam int CC_DL     = 8;
    localparam int CC_ACC_A_SAT_ENABLE   = 7;
    localparam int CC_ACC_B_SAT_ENABLE   = 6;
    localparam int CC_DSP_WRITE_SAT_ENABLE  = 5;
    localparam int CC_SUPER_SAT_SELECT = 4;
    localparam int CC_CPU_PRIORITY_MSB   = 3;
    localparam int CC_PSV    = 2;
    localparam int CC_RND    = 1;
    localparam int CC_IF     = 0;
    // reset values
    localparam logic [15:0] RST_STATUS = 16'h0000;
    localparam logic [15:0] RST_CORE   = 16'h0020;
    localparam logic [7:0]  RST_PAGE   = 8'h00;
    // core geometry
    localparam int          PC_W       = 23;
    localparam int          INSTR_W    = 24;
    localparam int          NUM_WREG   = 16;
    localparam int          WREG_W     = 16;
    localparam int          ACC_W      = 40;
    localparam int          SHIFT_MAX  = 16;
    localparam int          MUL_W      = 17;
    localparam int          PAGE_W     = 8;
    localparam int          WIN_OFF_W  = 15;
    localparam logic [7:0]  INFO_FLAGS = 8'h07;
    localparam logic [2:0]  IPL_TOP    = 3'h7;

    typedef struct packed {
        logic updC;
        logic updZ;
        logic updN;
        logic updOv;
        logic updDc;
        logic zSticky;
        logic carry;
        logic zero;
        logic neg;
        logic ovf;
        logic halfCarry;
    } alu_flags_s;
endpackage
`default_nettype wire

/* File: hdl/cpu_status_core_control.sv */
// Purpose: cpu status word, core control word, window page and core info registers, with
//          the shared multiplier, barrel shifter and data-to-program window mapping they steer
// Assumes: all core-side inputs come from logic on sys_clk; apb slave with no wait states
// Notes:   hardware flag updates win over a software write in the same cycle
`timescale 1ns/1ps
`default_nettype none
// Operation
// - program counter is 23 bits, instruction words are 24 bits
// - all instructions single cycle except flow changes, double-word move, table access
// - sixteen 16-bit working registers; the last is the stack pointer
// - 40-bit barrel shifter moves up to 16 places either way in one cycle
// - with window on, upper 32 Kbytes of data map to program space via page
// - accumulator overflow flags at bits 15 and 14 track overflow, read only
// - sticky saturation flags at bits 13 and 12; software clears, never sets
// - combined sticky flag readable, clearable; clearing it clears both accumulator flags
// - block loop active flag reads 1 while a counted loop runs
// - half carry at bit 8 captures low nibble or 8th-bit carry
// - priority is bit 3 of control over status bits 7-5; high half disables interrupts
// - priority status bits become read only while nesting disable is set
// - repeat active flag at bit 4 reads 1 during a repeat loop
// - negative flag at bit 3 follows sign of affecting result
// - overflow flag at bit 2 marks signed two's complement overflow
// - zero flag cleared by non-zero result, otherwise keeps its set state
// - carry flag at bit 0 records msb carry-out, borrow for subtraction
// - data-space write saturation enable resets to 1, clearing disables it
// - one 17x17 single-cycle multiplier serves alu and dsp, any operand signs
// - block and repeat loops have no overhead and accept interrupts any iteration
// - multiply-accumulate fetches x and y operands in the same cycle
// - modulo addressing in x and y spaces; bit-reversed in x only
// - combined overflow flag is always the or of both accumulator overflows
// - control bit selects signed or unsigned dsp multiplies
// - control bit selects fractional or integer dsp multiplies
// - control bit selects biased or convergent rounding; here the bit is only stored and read back, nothing rounds
module cpu_status_core_control
    import cpu_ctrl_pkg::*;
#(
    parameter int WIN_ADDR_W = 16
) (
    input  wire logic                          sys_clk,
    input  wire logic                          srst,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [cpu_ctrl_pkg::ADDR_W-1:0] paddr,
    input  wire logic [cpu_ctrl_pkg::DATA_W-1:0] pwdata,
    output var  logic [cpu_ctrl_pkg::DATA_W-1:0] prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire cpu_ctrl_pkg::alu_flags_s      aluFlags,
    input  wire logic                          accAOverflow,
    input  wire logic                          accBOverflow,
    input  wire logic                          accASatEvent,
    input  wire logic                          accBSatEvent,
    input  wire logic                          blockLoopBusy,
    input  wire logic                          repeatLoopBusy,
    input  wire logic [2:0]                    loopDepthIn,
    input  wire logic                          nestingDisable,
    input  wire logic                          priorityLoad,
    input  wire logic [3:0]                    priorityIn,
    input  wire logic [WIN_ADDR_W-1:0]         dataAddr,
    input  wire logic                          mulMcuMode,
    input  wire logic                          mcuSignA,
    input  wire logic                          mcuSignB,
    input  wire logic [cpu_ctrl_pkg::WREG_W-1:0] mulOpA,
    input  wire logic [cpu_ctrl_pkg::WREG_W-1:0] mulOpB,
    input  wire logic [cpu_ctrl_pkg::ACC_W-1:0]  shiftIn,
    input  wire logic                          shiftLeft,
    input  wire logic [4:0]                    shiftAmt,
    output var  logic [15:0]                   statusWord,
    output var  logic [15:0]                   coreControl,
    output logic [3:0]                         cpuPriority,
    output logic                               userIntDisabled,
    output var  logic                          earlyLoopExit,
    output logic                               progSpaceHit,
    output logic [cpu_ctrl_pkg::PC_W-1:0]      progAddr,
    output var  logic [cpu_ctrl_pkg::ACC_W-1:0]  mulProduct,
    output var  logic [cpu_ctrl_pkg::ACC_W-1:0]  shiftOut
);
    import cpu_ctrl_pkg::*;

    function automatic logic [ACC_W-1:0] barrel(input logic [ACC_W-1:0] v,
                                                input logic             left,
                                                input logic [4:0]       amt);
        logic [4:0] n;
        n = (amt > 5'(SHIFT_MAX)) ? 5'(SHIFT_MAX) : amt;
        return left ? (v << n) : ACC_W'($signed(v) >>> n);
    endfunction

    function automatic logic [MUL_W-1:0] extend(input logic [WREG_W-1:0] v, input logic sgn);
        return {sgn & v[WREG_W-1], v};
    endfunction

    // flags and fields held in flip-flops
    logic        oa_q, ob_q, sa_q, sb_q, da_q, ra_q;
    logic        dc_q, n_q, ov_q, z_q, c_q;
    logic [2:0]  ipl_q;
    logic        cpu_priority_msb_q;
    logic [2:0]  depth_q;
    logic [7:0]  ctrl_q;
    logic        us_q;
    logic [7:0]  page_q;
    logic        sa_d, sb_d, z_d;
    logic [31:0] rdData_q;

    // apb decode; no wait states, so access phase is also the completion edge
    wire         setup     = psel & ~penable;
    wire         access    = psel & penable;
    wire         hitStatus = (paddr == OFF_STATUS);
    wire         hitCore   = (paddr == OFF_CORE);
    wire         hitPage   = (paddr == OFF_PAGE);
    wire         hitInfo   = (paddr == OFF_INFO);
    wire         hitAny    = hitStatus | hitCore | hitPage | hitInfo;
    wire         wrStatus  = access & pwrite & hitStatus;
    wire         wrCore    = access & pwrite & hitCore;
    wire         wrPage    = access & pwrite & hitPage;
    wire  [15:0] wd        = pwdata[15:0];

    assign pready  = 1'b1;
    assign pslverr = access & ~hitAny;
    assign prdata  = rdData_q;

    wire  [31:0] infoWord = {INFO_FLAGS, 8'(NUM_WREG), 8'(INSTR_W), 8'(PC_W)};
    wire  [15:0] statusNow;
    wire  [15:0] coreNow;
    assign statusNow = {oa_q, ob_q, sa_q, sb_q, oa_q | ob_q, sa_q | sb_q, da_q, dc_q,
                        ipl_q, ra_q, n_q, ov_q, z_q, c_q};
    assign coreNow   = {3'h0, us_q, 1'b0, depth_q, ctrl_q[7:4], cpu_priority_msb_q, ctrl_q[2:0]};
    wire  [31:0] readMux = hitStatus ? {16'h0000, statusNow} :
                           hitCore   ? {16'h0000, coreNow}   :
                           hitPage   ? {24'h000000, page_q}  :
                           hitInfo   ? infoWord              : 32'h0000_0000;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdData_q <= 32'h0000_0000;
        end else if (setup) begin
            rdData_q <= readMux;
        end
    end

    // sticky saturation: a new event wins over a clear in the same cycle
    wire clrSab = wrStatus & ~wd[ST_SAB];
    assign sa_d = accASatEvent | (sa_q & ~(clrSab | (wrStatus & ~wd[ST_SA])));
    assign sb_d = accBSatEvent | (sb_q & ~(clrSab | (wrStatus & ~wd[ST_SB])));

    // sticky zero lets multi-precision ops keep a zero from earlier words
    assign z_d = aluFlags.updZ ? (aluFlags.zSticky ? (z_q & aluFlags.zero) : aluFlags.zero)
                               : (wrStatus ? wd[ST_Z] : z_q);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            {oa_q, ob_q, sa_q, sb_q, da_q, ra_q} <= 6'h00;
            {dc_q, n_q, ov_q, z_q, c_q}          <= RST_STATUS[4:0];
        end else begin
            oa_q <= accAOverflow;
            ob_q <= accBOverflow;
            sa_q <= sa_d;
            sb_q <= sb_d;
            da_q <= blockLoopBusy;
            ra_q <= repeatLoopBusy;
            dc_q <= aluFlags.updDc ? aluFlags.halfCarry : (wrStatus ? wd[ST_DC] : dc_q);
            n_q  <= aluFlags.updN  ? aluFlags.neg       : (wrStatus ? wd[ST_N]  : n_q);
            ov_q <= aluFlags.updOv ? aluFlags.ovf       : (wrStatus ? wd[ST_OV] : ov_q);
            z_q  <= z_d;
            c_q  <= aluFlags.updC  ? aluFlags.carry     : (wrStatus ? wd[ST_C]  : c_q);
        end
    end

    // priority: interrupt entry/return loads win; software writes bits 7-5 only when nesting allowed, clears the top bit any time
    wire iplSwWrite = wrStatus & ~nestingDisable;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ipl_q  <= RST_STATUS[7:5];
            cpu_priority_msb_q <= RST_CORE[CC_CPU_PRIORITY_MSB];
        end else begin
            if (priorityLoad) begin
                ipl_q <= priorityIn[2:0];
            end else if (iplSwWrite) begin
                ipl_q <= wd[7:5];
            end
            // software may only clear the top priority bit
            cpu_priority_msb_q <= priorityLoad ? priorityIn[3] : (cpu_priority_msb_q & ~(wrCore & ~wd[CC_CPU_PRIORITY_MSB]));
        end
    end
    assign cpuPriority     = {cpu_priority_msb_q, ipl_q};
    assign userIntDisabled = cpu_priority_msb_q | (ipl_q == IPL_TOP);

    // control word; the early-exit bit is a write-one pulse and reads as zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_q        <= {RST_CORE[7:4], 1'b0, RST_CORE[2:0]};
            us_q          <= RST_CORE[CC_US];
            page_q        <= RST_PAGE;
            depth_q       <= 3'h0;
            earlyLoopExit <= 1'b0;
        end else begin
            if (wrCore) begin
                ctrl_q <= {wd[7:4], 1'b0, wd[2:0]};
                us_q   <= wd[CC_US];
            end
            if (wrPage) begin
                page_q <= pwdata[PAGE_W-1:0];
            end
            depth_q       <= loopDepthIn;
            earlyLoopExit <= wrCore & wd[CC_EDT] & blockLoopBusy;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            statusWord  <= RST_STATUS;
            coreControl <= RST_CORE;
        end else begin
            statusWord  <= statusNow;
            coreControl <= coreNow;
        end
    end

    // program-space window: top half of data space lands on a 16K-word page
    assign progSpaceHit = ctrl_q[CC_PSV] & dataAddr[WIN_ADDR_W-1];
    assign progAddr     = {page_q, dataAddr[WIN_OFF_W-1:0]};

    // shared multiplier: 17-bit operands make mixed sign and (-1)x(-1) exact
    wire             sgnA  = mulMcuMode ? mcuSignA : ~us_q;
    wire             sgnB  = mulMcuMode ? mcuSignB : ~us_q;
    wire [MUL_W-1:0] opA   = extend(mulOpA, sgnA);
    wire [MUL_W-1:0] opB   = extend(mulOpB, sgnB);
    wire [33:0]      prod  = 34'($signed(opA) * $signed(opB));
    wire             frac  = ~mulMcuMode & ~ctrl_q[CC_IF];
    wire [32:0]      prod33 = frac ? {prod[31:0], 1'b0} : prod[32:0];

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mulProduct <= '0;
            shiftOut   <= '0;
        end else begin
            mulProduct <= {{(ACC_W-33){prod33[32]}}, prod33};
            shiftOut   <= barrel(shiftIn, shiftLeft, shiftAmt);
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_status_wr;
        psel && penable && pwrite && paddr == OFF_STATUS;
    endsequence
    sequence s_core_wr;
        psel && penable && pwrite && paddr == OFF_CORE;
    endsequence

    chk_sat_sticky: assert property (accASatEvent |=> sa_q ##1 (sa_q || $past(wrStatus)))
        else $error("accumulator a saturation flag lost after event");
    chk_sab_clear: assert property ((s_status_wr and !pwdata[ST_SAB] && !accASatEvent && !accBSatEvent)
                                    |=> !sa_q && !sb_q && !statusNow[ST_SAB])
        else $error("combined sticky clear did not clear both flags");
    chk_oab_or: assert property (statusNow[ST_OAB] == (statusNow[ST_OA] || statusNow[ST_OB]))
        else $error("combined overflow not the or of accumulator overflows");
    chk_ovf_track: assert property (##1 oa_q == $past(accAOverflow) && ob_q == $past(accBOverflow))
        else $error("accumulator overflow flag does not track its source");
    chk_ipl_lock: assert property ((nestingDisable && !priorityLoad) |=> ipl_q == $past(ipl_q))
        else $error("priority bits changed while nesting disabled");
    chk_user_mask: assert property (cpuPriority >= 4'h7 |-> userIntDisabled)
        else $error("user interrupts not disabled at high priority");
    chk_edt_pulse: assert property ((s_core_wr and pwdata[CC_EDT] && blockLoopBusy)
                                    |=> earlyLoopExit ##1 !earlyLoopExit)
        else $error("early loop exit pulse wrong");
    chk_zero_keep: assert property ((aluFlags.updZ && aluFlags.zSticky && !z_q) |=> !z_q)
        else $error("sticky zero flag set again");
    chk_win_map: assert property (progSpaceHit |-> progAddr[PC_W-1 -: PAGE_W] == page_q
                                  && ctrl_q[CC_PSV])
        else $error("program window mapping wrong");
    chk_dsp_write_sat_enable_reset: assert property ($fell(srst) |-> coreNow[CC_DSP_WRITE_SAT_ENABLE])
        else $error("data write saturation not enabled after reset");
    chk_mul_int: assert property ((mulMcuMode && !mcuSignA && !mcuSignB)
                                  |=> mulProduct == ACC_W'({$past(mulOpA)} * {$past(mulOpB)}))
        else $error("unsigned multiply result wrong");
    chk_sat_no_set: assert property ((s_status_wr and !accASatEvent && !sa_q) |=> !sa_q)
        else $error("software write set accumulator a saturation flag");
    chk_loop_track: assert property (##1 da_q == $past(blockLoopBusy)
                                     && ra_q == $past(repeatLoopBusy))
        else $error("loop active flags do not track their sources");
    chk_depth_track: assert property (##1 depth_q == $past(loopDepthIn))
        else $error("loop nesting depth does not track its source");
    chk_msb_clear: assert property ((s_core_wr and !pwdata[CC_CPU_PRIORITY_MSB] && !priorityLoad) |=> !cpu_priority_msb_q)
        else $error("priority top bit not cleared by software");
    chk_page_write: assert property ((psel && penable && pwrite && paddr == OFF_PAGE)
                                     |=> page_q == $past(pwdata[PAGE_W-1:0]))
        else $error("window page write lost");
    chk_shift_clamp: assert property ((shiftLeft && shiftAmt >= 5'h10)
                                      |=> shiftOut == ($past(shiftIn) << SHIFT_MAX))
        else $error("long left shift not clamped to sixteen places");
endmodule
`default_nettype wire

/* File: test/cpu_status_core_control_bench.sv */
// Purpose: self-checking bench for the cpu status and core control bank
// Assumes: apb slave answers on its own; core-side inputs change right after a clock edge
// Notes:   expectations come from bench functions; flags are read a few cycles after their cause
`timescale 1ns/1ps
`default_nettype none
module cpu_status_core_control_bench;
    import cpu_ctrl_pkg::*;
    logic        sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdata;
    logic        pready, pslverr, rerr, userIntDisabled, earlyLoopExit, progSpaceHit;
    alu_flags_s  aluFlags = '0, f;
    logic        accAOverflow = 1'b0, accBOverflow = 1'b0, accASatEvent = 1'b0, accBSatEvent = 1'b0;
    logic        blockLoopBusy = 1'b0, repeatLoopBusy = 1'b0, nestingDisable = 1'b0, priorityLoad = 1'b0;
    logic        mulMcuMode = 1'b0, mcuSignA = 1'b0, mcuSignB = 1'b0, shiftLeft = 1'b0;
    logic [2:0]  loopDepthIn = '0;
    logic [3:0]  priorityIn = '0, cpuPriority;
    logic [15:0] dataAddr = '0, mulOpA = '0, mulOpB = '0, statusWord, coreControl, a, b, w;
    logic [39:0] shiftIn = '0, mulProduct, shiftOut, s;
    logic [4:0]  shiftAmt = '0, e = '0;
    logic [22:0] progAddr;
    logic [7:0]  pg;
    int          fails = 0, n_checks = 0, cnt, k;

    cpu_status_core_control dut (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .aluFlags(aluFlags), .accAOverflow(accAOverflow), .accBOverflow(accBOverflow),
        .accASatEvent(accASatEvent), .accBSatEvent(accBSatEvent), .blockLoopBusy(blockLoopBusy),
        .repeatLoopBusy(repeatLoopBusy), .loopDepthIn(loopDepthIn), .nestingDisable(nestingDisable),
        .priorityLoad(priorityLoad), .priorityIn(priorityIn), .dataAddr(dataAddr), .mulMcuMode(mulMcuMode),
        .mcuSignA(mcuSignA), .mcuSignB(mcuSignB), .mulOpA(mulOpA), .mulOpB(mulOpB), .shiftIn(shiftIn),
        .shiftLeft(shiftLeft), .shiftAmt(shiftAmt), .statusWord(statusWord), .coreControl(coreControl),
        .cpuPriority(cpuPriority), .userIntDisabled(userIntDisabled), .earlyLoopExit(earlyLoopExit),
        .progSpaceHit(progSpaceHit), .progAddr(progAddr), .mulProduct(mulProduct), .shiftOut(shiftOut));

    always #2.5 sys_clk = ~sys_clk;

    task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // request held from setup until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        int wd;
        wd = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && wd < 50) begin
            wd++;
            @(posedge sys_clk);
        end
        if (wd == 50) begin
            fails++;
            $display("ERROR at %0t: apb transfer got no ready", $time);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [4:0] alu_model(input logic [4:0] o, input alu_flags_s x);
        logic [4:0] r;
        r = o;
        if (x.updDc) r[4] = x.halfCarry;
        if (x.updN) r[3] = x.neg;
        if (x.updOv) r[2] = x.ovf;
        if (x.updZ) r[1] = x.zSticky ? (o[1] & x.zero) : x.zero;
        if (x.updC) r[0] = x.carry;
        return r;
    endfunction

    function automatic logic [39:0] mul_model(input logic [15:0] x, input logic [15:0] y,
                                              input logic sx, input logic sy);
        longint p;
        p = (sx ? longint'($signed(x)) : longint'(x)) * (sy ? longint'($signed(y)) : longint'(y));
        return p[39:0];
    endfunction

    task automatic pulse_count();
        cnt = 0;
        repeat (4) begin
            @(posedge sys_clk);
            if (earlyLoopExit === 1'b1) cnt++;
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        tick(20000);
        fails++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h69191d67));
        tick(6);
        srst <= 1'b0;
        apb(1'b0, OFF_STATUS, '0);
        check(rdata, 32'h0, "status reset");
        apb(1'b0, OFF_CORE, '0);
        check(rdata, 32'h0000_0020, "control reset");
        apb(1'b0, OFF_INFO, '0);
        check(rdata[23:0], 24'h10_18_17, "info");
        apb(1'b0, 12'h010, '0);
        check({rerr, rdata}, {1'b1, 32'h0}, "unmapped");
        for (int i = 0; i < 4; i++) begin
            accAOverflow <= i[0];
            accBOverflow <= i[1];
            blockLoopBusy <= i[1];
            repeatLoopBusy <= i[0];
            tick(2);
            apb(1'b1, OFF_STATUS, 32'h0000_C210); // read-only bits ignore writes
            apb(1'b0, OFF_STATUS, '0);
            check({rdata[15:14], rdata[11], rdata[9], rdata[4]}, {i[0], i[1], i[0] | i[1], i[1], i[0]},
                  "overflow and loop flags");
        end
        {accAOverflow, accBOverflow, blockLoopBusy, repeatLoopBusy} <= 4'h0;
        accASatEvent <= 1'b1;
        tick(1);
        accASatEvent <= 1'b0;
        tick(3);
        check({statusWord[13:12], statusWord[10]}, 3'b101, "sticky out");
        apb(1'b1, OFF_STATUS, 32'h0000_1400);
        apb(1'b0, OFF_STATUS, '0);
        check({rdata[13:12], rdata[10]}, 3'b000, "sticky clear a");
        {accASatEvent, accBSatEvent} <= 2'b11;
        tick(1);
        {accASatEvent, accBSatEvent} <= 2'b00;
        tick(2);
        apb(1'b1, OFF_STATUS, 32'h0000_3000);
        apb(1'b0, OFF_STATUS, '0);
        check({rdata[13:12], rdata[10]}, 3'b000, "combined clear");
        apb(1'b1, OFF_STATUS, 32'h0000_3400);
        apb(1'b0, OFF_STATUS, '0);
        check({rdata[13:12], rdata[10]}, 3'b000, "sticky no set");
        for (int v = 0; v < 8; v++) begin
            apb(1'b1, OFF_STATUS, 32'(v) << 5);
            apb(1'b0, OFF_STATUS, '0);
            check({rdata[7:5], cpuPriority, userIntDisabled}, {v[2:0], 1'b0, v[2:0], v == 7}, "level");
        end
        nestingDisable <= 1'b1;
        apb(1'b1, OFF_STATUS, 32'h0000_0040);
        apb(1'b0, OFF_STATUS, '0);
        check(rdata[7:5], 3'h7, "level locked");
        nestingDisable <= 1'b0;
        priorityLoad <= 1'b1;
        priorityIn <= 4'hA;
        tick(1);
        priorityLoad <= 1'b0;
        tick(2);
        apb(1'b0, OFF_CORE, '0);
        check({cpuPriority, userIntDisabled, rdata[3]}, 6'b1010_11, "level load");
        apb(1'b1, OFF_CORE, 32'h0000_0020);
        apb(1'b1, OFF_CORE, 32'h0000_0028);
        apb(1'b0, OFF_CORE, '0);
        check({cpuPriority, userIntDisabled, rdata[3]}, 6'b0010_00, "level msb clear only");
        for (int i = 0; i < 24; i++) begin
            f = alu_flags_s'(11'($urandom));
            aluFlags <= f;
            tick(1);
            aluFlags <= '0;
            e = alu_model(e, f);
            tick(2);
            apb(1'b0, OFF_STATUS, '0);
            check({rdata[8], rdata[3:0]}, e, "alu flags");
        end
        for (int i = 0; i < 12; i++) begin
            w = (i == 0) ? 16'h0 : (i == 1) ? 16'h10F7 : 16'($urandom) & 16'h10F7;
            loopDepthIn <= 3'($urandom);
            apb(1'b1, OFF_CORE, {16'h0, w});
            tick(2);
            apb(1'b0, OFF_CORE, '0);
            check(rdata, {16'h0, w | {5'h0, loopDepthIn, 8'h0}}, "control");
            check(coreControl, w | {5'h0, loopDepthIn, 8'h0}, "control out");
        end
        blockLoopBusy <= 1'b1;
        apb(1'b1, OFF_CORE, 32'h0000_0824);
        pulse_count();
        check(cnt, 1, "exit pulse");
        apb(1'b0, OFF_CORE, '0);
        check(rdata[11], 1'b0, "exit reads zero");
        blockLoopBusy <= 1'b0;
        apb(1'b1, OFF_CORE, 32'h0000_0824);
        pulse_count();
        check(cnt, 0, "exit idle");
        for (int i = 0; i < 8; i++) begin
            pg = 8'($urandom);
            apb(1'b1, OFF_PAGE, {24'h0, pg});
            apb(1'b1, OFF_CORE, 32'h0000_0020 | (32'(i[0]) << 2));
            dataAddr <= 16'($urandom);
            tick(2);
            check({progSpaceHit, progAddr}, {i[0] & dataAddr[15], pg, dataAddr[14:0]}, "window");
        end
        mulMcuMode <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            a = (i < 4) ? 16'h8000 : 16'($urandom);
            b = (i < 4) ? 16'h8000 : 16'($urandom);
            {mulOpA, mulOpB, mcuSignA, mcuSignB} <= {a, b, i[0], i[1]};
            tick(2);
            check(mulProduct, mul_model(a, b, i[0], i[1]), "product");
        end
        // dsp mode: signedness from the control word, fractional results doubled
        mulMcuMode <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 16'h8000 : 16'($urandom);
            b = (i == 0) ? 16'h8000 : 16'($urandom);
            apb(1'b1, OFF_CORE, 32'h0000_0020 | (32'(i[1]) << CC_US) | 32'(i[0]));
            {mulOpA, mulOpB} <= {a, b};
            tick(2);
            s = mul_model(a, b, !i[1], !i[1]);
            check(mulProduct, i[0] ? s : {{7{s[31]}}, s[31:0], 1'b0}, "dsp product");
        end
        for (int i = 0; i < 12; i++) begin
            s = {8'($urandom), 32'($urandom)} & 40'h7F_FFFF_FFFF;
            k = (i == 0) ? 20 : int'($urandom % 17);
            {shiftIn, shiftLeft, shiftAmt} <= {s, i[0] | (i == 0), 5'(k)};
            tick(2);
            k = (k > 16) ? 16 : k;
            check(shiftOut, (i[0] | (i == 0)) ? s << k : s >> k, "shift");
        end
        // second reset in mid-run, with results and flags left non-zero
        srst <= 1'b1;
        tick(2);
        check({statusWord, coreControl}, {RST_STATUS, RST_CORE}, "reset words");
        check(mulProduct | shiftOut, 40'h0, "reset results");
        srst <= 1'b0;
        apb(1'b0, OFF_CORE, '0);
        check(rdata, 32'h0000_0020, "control after reset");
        wrap_up();
    end
endmodule
`default_nettype wire
